// >>> hdl/hdcb_defs.vh
// constants for the host decode configuration bits block
`ifndef HDCB_DEFS_VH
`define HDCB_DEFS_VH

`define HDCB_OFS_GAP_CTL      8'h58
`define HDCB_OFS_HOST_CFG     8'h50
`define HDCB_GAP_CTL_RESET    8'h00
`define HDCB_HOST_CFG_RESET   8'h00
`define HDCB_BIT_GAP_ON       7
`define HDCB_BIT_STRAP        2
`define HDCB_BIT_INTWIN_DIS   1
`define HDCB_OTQ_DEEP         4'hC
`define HDCB_OTQ_SHALLOW      4'h1
`define HDCB_OTQ_OWN          4'h8
`define HDCB_GAP_LO           36'h0_00F0_0000
`define HDCB_GAP_HI           36'h0_00FF_FFFF
`define HDCB_WIN0_LO          36'h0_FEC0_0000
`define HDCB_WIN0_HI          36'h0_FEC7_FFFF
`define HDCB_WIN1_LO          36'h0_FEC8_0000
`define HDCB_WIN1_HI          36'h0_FEC8_0FFF
`define HDCB_WIN2_LO          36'h0_FEC8_1000
`define HDCB_WIN2_HI          36'h0_FEC8_1FFF
`define HDCB_RT_NONE          3'h0
`define HDCB_RT_PORT0         3'h1
`define HDCB_RT_PORT1         3'h2
`define HDCB_RT_PORT2         3'h3
`define HDCB_RT_GENERAL       3'h4
`define HDCB_RT_DRAM          3'h5

`endif

// >>> hdl/hdcb_otq_limit.v
// outstanding transaction counter that drives block-next-request
`timescale 1ns/100ps
`default_nettype none
module hdcb_otq_limit #(
  parameter W = 4
) (
  input  wire         clk_i,
  input  wire         rst_b_i,
  input  wire         issue_i,
  input  wire         retire_i,
  input  wire [W-1:0] limit_i,
  output reg  [W-1:0] count_o,
  output reg          block_next_request_o
);
  reg [W-1:0] count_d;

  always @*
  begin
    count_d = count_o;
    if (issue_i && !retire_i)
      count_d = count_o + {{(W-1){1'b0}}, 1'b1};
    else if (retire_i && !issue_i && count_o != {W{1'b0}})
      count_d = count_o - {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count_o              <= {W{1'b0}};
      block_next_request_o <= 1'b0;
    end
    else
    begin
      count_o              <= count_d;
      // flag is taken from the next count, so it rises in the same cycle the count reaches the limit
      block_next_request_o <= (count_d >= limit_i); // RULE3
    end
  end
endmodule // hdcb_otq_limit
`default_nettype wire

// >>> hdl/hdcb_top.v
// host decode configuration bits: strap capture, window routing, dram gap
// Notes on behaviour
// RULE1: latch address bit 7 at processor reset release
// RULE2: strap one gives queue depth twelve
// RULE3: block next request beyond eight outstanding
// RULE4: strap zero gives queue depth one
// RULE5: never drive address bit 7 during reset
// RULE6: external agent holds bit 7 low for depth one
// RULE7: window disable set uses general decode
// RULE8: lowest interrupt window goes to port zero
// RULE9: next 4 KB window goes to port one
// RULE10: following 4 KB window goes to port two
// RULE11: gap on opens 15 to 16 MB hole
// RULE12: gap off decodes ordinary dram, reset value
// RULE13: host cycles in hole go to port zero
// RULE14: hub cycles in hole are not claimed
// RULE15: dram behind hole is not relocated
// RULE16: reserved gap control bits read zero
`timescale 1ns/100ps
`default_nettype none
`include "hdcb_defs.vh"
module hdcb_top #(
  parameter AW = 36
) (
  input  wire          clk_i,
  input  wire          rst_b_i,
  input  wire          processor_reset_out_i,
  input  wire          host_addr_bit7_strap_pin_i,
  output reg           host_addr_bit7_strap_pin_o,
  output reg           host_addr_bit7_strap_pin_oe_o,
  input  wire [7:0]    reg_addr_i,
  input  wire [7:0]    reg_wdata_i,
  input  wire          reg_wr_i,
  input  wire          reg_rd_i,
  output reg  [7:0]    reg_rdata_o,
  input  wire          host_valid_i,
  input  wire [AW-1:0] host_addr_i,
  input  wire          hub_valid_i,
  input  wire [AW-1:0] hub_addr_i,
  input  wire          txn_issue_i,
  input  wire          txn_retire_i,
  output reg  [2:0]    host_route_o,
  output reg           hub_claim_o,
  output reg  [3:0]    queue_depth_o,
  output wire          block_next_request_o,
  output wire [3:0]    outstanding_o
);
  reg        strap_q;
  reg        cpu_rst_q;
  reg        gap_on_q;
  reg        intwin_dis_q;
  reg  [2:0] route_d;
  reg        claim_d;
  reg  [7:0] rdata_d;
  wire       host_in_gap;
  wire       hub_in_gap;
  wire       in_win0;
  wire       in_win1;
  wire       in_win2;

  // strap sampled on the clocked release edge, never from the async reset
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cpu_rst_q <= 1'b1;
      strap_q   <= 1'b1;
    end
    else
    begin
      cpu_rst_q <= processor_reset_out_i;
      if (cpu_rst_q && !processor_reset_out_i)
        strap_q <= host_addr_bit7_strap_pin_i; // RULE1 RULE6
    end
  end

  // pin is only ever released; this slice owns no host address drive
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      host_addr_bit7_strap_pin_o    <= 1'b0;
      host_addr_bit7_strap_pin_oe_o <= 1'b0;
    end
    else
    begin
      host_addr_bit7_strap_pin_o    <= 1'b0;
      host_addr_bit7_strap_pin_oe_o <= 1'b0; // RULE5
    end
  end

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      queue_depth_o <= `HDCB_OTQ_SHALLOW;
    else if (strap_q)
      queue_depth_o <= `HDCB_OTQ_DEEP; // RULE2
    else
      queue_depth_o <= `HDCB_OTQ_SHALLOW; // RULE4
  end

  // depth one needs no extra stalling: the processor issues one at a time
  hdcb_otq_limit #(
    .W (4)
  ) u_limit (
    .clk_i                (clk_i),
    .rst_b_i              (rst_b_i),
    .issue_i              (txn_issue_i),
    .retire_i             (txn_retire_i),
    .limit_i              (`HDCB_OTQ_OWN),
    .count_o              (outstanding_o),
    .block_next_request_o (block_next_request_o)
  );

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gap_on_q     <= 1'b0; // RULE12
      intwin_dis_q <= 1'b0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `HDCB_OFS_GAP_CTL)
        gap_on_q <= reg_wdata_i[`HDCB_BIT_GAP_ON]; // RULE16
      else if (reg_addr_i == `HDCB_OFS_HOST_CFG)
        intwin_dis_q <= reg_wdata_i[`HDCB_BIT_INTWIN_DIS];
    end
  end

  always @*
  begin
    rdata_d = 8'h00;
    if (reg_addr_i == `HDCB_OFS_GAP_CTL)
      rdata_d[`HDCB_BIT_GAP_ON] = gap_on_q; // RULE16
    else if (reg_addr_i == `HDCB_OFS_HOST_CFG)
    begin
      rdata_d[`HDCB_BIT_STRAP]      = strap_q; // RULE1
      rdata_d[`HDCB_BIT_INTWIN_DIS] = intwin_dis_q;
    end
  end

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_d;
    else
      reg_rdata_o <= 8'h00;
  end

  assign host_in_gap = gap_on_q && host_addr_i >= `HDCB_GAP_LO
                       && host_addr_i <= `HDCB_GAP_HI; // RULE11
  assign hub_in_gap  = gap_on_q && hub_addr_i >= `HDCB_GAP_LO
                       && hub_addr_i <= `HDCB_GAP_HI; // RULE11
  assign in_win0 = host_addr_i >= `HDCB_WIN0_LO && host_addr_i <= `HDCB_WIN0_HI;
  assign in_win1 = host_addr_i >= `HDCB_WIN1_LO && host_addr_i <= `HDCB_WIN1_HI;
  assign in_win2 = host_addr_i >= `HDCB_WIN2_LO && host_addr_i <= `HDCB_WIN2_HI;

  always @*
  begin
    route_d = `HDCB_RT_NONE;
    if (host_valid_i)
    begin
      if (host_in_gap)
        route_d = `HDCB_RT_PORT0; // RULE13 RULE15
      else if ((in_win0 || in_win1 || in_win2) && intwin_dis_q)
        route_d = `HDCB_RT_GENERAL; // RULE7
      else if (in_win0)
        route_d = `HDCB_RT_PORT0; // RULE8
      else if (in_win1)
        route_d = `HDCB_RT_PORT1; // RULE9
      else if (in_win2)
        route_d = `HDCB_RT_PORT2; // RULE10
      else
        route_d = `HDCB_RT_DRAM; // RULE12
    end
  end

  always @*
  begin
    claim_d = hub_valid_i && !hub_in_gap; // RULE14
  end

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      host_route_o <= `HDCB_RT_NONE;
      hub_claim_o  <= 1'b0;
    end
    else
    begin
      host_route_o <= route_d;
      hub_claim_o  <= claim_d;
    end
  end
endmodule // hdcb_top
`default_nettype wire

// >>> tb/hdcb_chk_asserts.sv
// assertions on the host decode configuration ports
`timescale 1ns/100ps
`default_nettype none
module hdcb_chk (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       host_addr_bit7_strap_pin_oe_o,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [3:0] queue_depth_o,
  input wire logic       block_next_request_o,
  input wire logic [3:0] outstanding_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  pin_idle_a: assert property (!host_addr_bit7_strap_pin_oe_o)
    else $error("pin driven");
  depth_set_a: assert property (queue_depth_o inside {4'hC, 4'h1})
    else $error("bad depth");
  bnr_limit_a: assert property (block_next_request_o == (outstanding_o >= 4'h8))
    else $error("bnr level");
  queue_cap_a: assert property (outstanding_o <= 4'h8)
    else $error("over eight");
  bnr_rise_a: assert property ($rose(block_next_request_o) |-> outstanding_o == 4'h8)
    else $error("bnr rise");
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("rdata idle");
  gap_rsvd_a: assert property ($past(reg_rd_i && reg_addr_i == 8'h58) |->
    reg_rdata_o[6:0] == 7'h00) else $error("reserved bits");
  unmapped_a: assert property ($past(reg_rd_i && !(reg_addr_i inside {8'h50, 8'h58}))
    |-> reg_rdata_o == 8'h00) else $error("unmapped read");
endmodule // hdcb_chk
bind hdcb_top hdcb_chk chk (.*);
`default_nettype wire

// >>> tb/hdcb_cpu_model.sv
// processor side model of the strap wire
`timescale 1ns/100ps
`default_nettype none
module hdcb_cpu_model (
  input wire logic hold_low_i,
  input wire logic oe_i,
  input wire logic pin_i,
  output var logic pin_o
);
  // pull-up wins unless an agent pulls low
  assign pin_o = hold_low_i ? 1'h0 : oe_i ? pin_i : 1'h1;
endmodule // hdcb_cpu_model
`default_nettype wire

// >>> tb/testbench.sv
// bench for the host decode configuration bits
`timescale 1ns/100ps
`default_nettype none
`include "hdcb_defs.vh"
module testbench;
  logic        clk_i = 0, rst_b_i = 0, processor_reset_out_i = 1, low = 0;
  logic        reg_wr_i = 0, reg_rd_i = 0, host_valid_i = 0, hub_valid_i = 0;
  logic        txn_issue_i = 0, txn_retire_i = 0, hub_claim_o, block_next_request_o;
  logic        host_addr_bit7_strap_pin_i, host_addr_bit7_strap_pin_o;
  logic        host_addr_bit7_strap_pin_oe_o;
  logic [2:0]  host_route_o;
  logic [3:0]  queue_depth_o, outstanding_o;
  logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic [35:0] host_addr_i = 0, hub_addr_i = 0, w [6];
  int          n_errors = 0, samples_checked = 0;
  hdcb_top dut (.*);
  hdcb_cpu_model cpu (.hold_low_i(low), .oe_i(host_addr_bit7_strap_pin_oe_o),
    .pin_i(host_addr_bit7_strap_pin_o), .pin_o(host_addr_bit7_strap_pin_i));
  initial forever #20 clk_i = ~clk_i;
  task automatic chk(input string s, input logic [7:0] v, e);
    samples_checked++;
    n_errors += (v !== e);
    if (v !== e) $display("CHECK FAILED %s expected %h seen %h", s, e, v);
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, d);
    @(posedge clk_i);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {wr, !wr, a, d};
    @(posedge clk_i);
    {reg_wr_i, reg_rd_i} <= 2'h0;
    #1 if (!wr) chk("rdata", reg_rdata_o, d);
  endtask
  task automatic rt(input logic [35:0] a, input logic [2:0] e, input logic c);
    @(posedge clk_i);
    {host_valid_i, hub_valid_i, host_addr_i, hub_addr_i} <= {2'h3, a, a};
    @(posedge clk_i);
    {host_valid_i, hub_valid_i} <= 2'h0;
    #1 chk("route", 8'(host_route_o), 8'(e));
    chk("claim", 8'(hub_claim_o), 8'(c));
  endtask
  task automatic strap(input logic l, input logic [3:0] e);
    @(posedge clk_i);
    {low, processor_reset_out_i} <= {l, 1'h1};
    repeat (4) @(posedge clk_i);
    chk("pin drive", {6'h00, host_addr_bit7_strap_pin_oe_o, host_addr_bit7_strap_pin_o}, 8'h00);
    processor_reset_out_i <= 0;
    repeat (4) @(posedge clk_i);
    low <= 0;
    #1 chk("depth", 8'(queue_depth_o), 8'(e));
  endtask
  task automatic bnr(input logic i, r, input logic [7:0] e);
    @(posedge clk_i);
    {txn_issue_i, txn_retire_i} <= {i, r};
    repeat (i ? 8 : 1) @(posedge clk_i);
    {txn_issue_i, txn_retire_i} <= 2'h0;
    #1 chk("bnr", {block_next_request_o, 3'h0, outstanding_o}, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    w = '{`HDCB_WIN0_LO, `HDCB_WIN0_HI, `HDCB_WIN1_LO,
          `HDCB_WIN1_HI, `HDCB_WIN2_LO, `HDCB_WIN2_HI};
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1;
    acc(0, 8'h58, 8'h00);
    strap(0, 4'hC);
    acc(0, 8'h50, 8'h04);
    acc(1, 8'h58, 8'hFF);
    acc(0, 8'h58, 8'h80);
    acc(1, 8'h40, 8'hFF);
    acc(0, 8'h40, 8'h00);
    rt(`HDCB_GAP_LO, 3'h1, 0);
    rt(`HDCB_GAP_HI, 3'h1, 0);
    rt(36'h0_0100_0000, 3'h5, 1);
    for (int i = 0; i < 6; i++) rt(w[i], 3'(1 + i / 2), 1);
    acc(1, 8'h50, 8'h02);
    for (int i = 0; i < 6; i++) rt(w[i], 3'h4, 1);
    acc(1, 8'h58, 8'h00);
    rt(`HDCB_GAP_LO, 3'h5, 1);
    bnr(1, 0, 8'h88);
    bnr(0, 1, 8'h07);
    strap(1, 4'h1);
    acc(0, 8'h50, 8'h02);
    print_verdict;
  end
  // far beyond the roughly 84 cycles the sequence needs
  initial
  begin
    #100000;
    n_errors++;
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
